// File: rtl/pkt_pkg.sv
// Purpose: shared constants for the packet length and format control block
// Assumes: register index times four gives the Wishbone byte address
// Notes: checksum is a 16-bit CCITT style code, high byte on air first
package pkt_pkg;
  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_RX_START = 10'h125; // receive_buffer_start
  localparam logic [9:0] IDX_FORMAT = 10'h126; // packet_format_control
  localparam logic [9:0] IDX_LIMIT = 10'h127; // packet_size_limit
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h140; // sticky events
  localparam logic [9:0] IDX_IRQ_MASK = 10'h141; // event enables
  localparam logic [9:0] IDX_RX_INFO = 10'h142; // last receive result
  // ----------------------------------------------------------------------
  // format control fields
  // ----------------------------------------------------------------------
  localparam int BIT_ORDER_POS = 7; // 1 msb first, 0 lsb first
  localparam int FIXED_SIZE_POS = 6; // fixed_size_select
  localparam int CHECKSUM_POS = 5; // checksum append and check
  localparam int MODE_LSB = 3; // transfer style, two bits
  localparam int BIAS_LSB = 0; // length bias, three bits
  localparam logic [1:0] MODE_PACKET = 2'h0; // packet buffer mode
  // ----------------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------------
  localparam int EV_TX_DONE = 0;
  localparam int EV_RX_DONE = 1;
  localparam int EV_CRC_BAD = 2;
  localparam int EV_PREAMBLE = 3;
  // ----------------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] RX_START_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [9:0] LENGTH_CORRECTION = 10'h004; // subtracted from sum
  localparam logic [8:0] CRC_BYTES = 9'h002; // checksum bytes on air
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // one byte through the checksum, msb of the byte first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_byte
endpackage : pkt_pkg

// File: rtl/byte_serializer.sv
// Purpose: shifts one byte out as eight bits, one per clock
// Assumes: load only while busy is low
// Notes: the order is latched with the byte
`timescale 1ns/1ps
`default_nettype none
module byte_serializer (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic msb_first,
  output logic busy,
  output logic bit_out,
  output logic bit_valid
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sh; // bits still to send
    logic [3:0] left; // bits remaining
    logic msb; // latched order
    logic out; // bit on the wire
    logic valid; // bit strobe
  } ser_t;
  ser_t s_q;
  ser_t s_d;

  // next state: load, then shift one bit each clock
  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (s_q.left != 4'h0)
    begin
      // order chosen per byte
      s_d.out = s_q.msb ? s_q.sh[7] : s_q.sh[0];
      s_d.sh = s_q.msb ? {s_q.sh[6:0], 1'b0} : {1'b0, s_q.sh[7:1]};
      s_d.valid = 1'b1;
      s_d.left = s_q.left - 4'h1;
    end
    else if (load)
    begin
      s_d.sh = data;
      s_d.msb = msb_first;
      s_d.left = 4'h8;
    end
  end

  // register the state
  always_ff @(posedge clock)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign busy = (s_q.left != 4'h0);
  assign bit_out = s_q.out;
  assign bit_valid = s_q.valid;
endmodule : byte_serializer
`default_nettype wire

// File: rtl/packet_length_format_control.sv
// Purpose: packet format control, length handling and air bit framing
// Assumes: classic Wishbone slave, 32-bit data, registers in low byte, receive info in bits 9:0
// Notes: one clock, synchronous active-high reset
//
// Operation
// - bit order bit picks msb or lsb first
// - fixed mode: limit register sets both lengths
// - variable receive: length from first byte
// - variable transmit: length from limit register
// - checksum on: append on send, check receive
// - checksum off: none appended, none checked
// - mode zero uses packet buffer path
// - serial mode streams bits, preamble raises pin
// - payload is length byte plus bias minus four
// - variable mode: limit caps stored byte count
// - fixed mode: limit is exact byte count
// - length excludes sync, checksum and bias
// - received bytes stored from buffer start address
`timescale 1ns/1ps
`default_nettype none
module packet_length_format_control (
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // transmit byte source
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  output logic tx_data_ready,
  // air side bits
  output logic air_tx_bit,
  output logic air_tx_valid,
  input wire logic air_rx_bit,
  input wire logic air_rx_valid,
  input wire logic rx_sync,
  input wire logic preamble_detect,
  // packet buffer write port
  output logic buf_wr_en,
  output logic [7:0] buf_wr_addr,
  output logic [7:0] buf_wr_data,
  // serial port
  input wire logic sport_tx_bit,
  input wire logic sport_tx_valid,
  output logic sport_rx_bit,
  output logic sport_rx_valid,
  output logic general_pin_four
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {T_IDLE, T_FETCH, T_DRAIN} tx_state_t;
  typedef enum logic [0:0] {R_IDLE, R_RECV} rx_state_t;

  typedef struct packed {
    logic [7:0] format; // packet_format_control
    logic [7:0] limit; // packet_size_limit
    logic [7:0] rx_start; // receive_buffer_start
    logic [3:0] irq_status; // sticky events
    logic [3:0] irq_mask; // event enables
    logic ack; // bus answer
    logic [31:0] rdata; // bus read data
    tx_state_t tx_st; // transmit sequencer
    logic [8:0] tx_cnt; // bytes handed out
    logic [15:0] tx_crc; // running transmit checksum
    logic ser_load; // load strobe to serializer
    logic [7:0] ser_byte; // byte to serializer
    rx_state_t rx_st; // receive sequencer
    logic [7:0] rx_sh; // byte assembly
    logic [2:0] rx_bits; // bits in assembly
    logic [8:0] rx_cnt; // bytes received
    logic [8:0] rx_target; // data bytes expected
    logic [8:0] rx_keep; // data bytes stored
    logic [15:0] rx_crc; // running receive checksum
    logic [7:0] rx_crc_hi; // first checksum byte seen
    logic [8:0] rx_len; // last computed payload length
    logic rx_crc_bad; // last checksum result
    logic wr_en; // buffer write strobe
    logic [7:0] wr_addr; // buffer write address
    logic [7:0] wr_data; // buffer write data
    logic air_bit; // bit to air
    logic air_valid; // bit strobe to air
    logic sp_bit; // bit to serial port
    logic sp_valid; // strobe to serial port
    logic gp4; // preamble pulse
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------------
  // decodes
  // ----------------------------------------------------------------------
  // true when the word address matches a register index
  function automatic logic reg_hit(input logic [11:0] adr,
                                   input logic [9:0] idx);
    return adr[11:2] == idx;
  endfunction : reg_hit

  logic req; // new bus request this cycle
  logic wr_lane; // write that touches the register byte
  logic msb_first; // current order selection
  logic fixed_size; // fixed length mode
  logic checksum_on; // checksum enabled
  logic packet_mode; // packet buffer path selected
  logic [2:0] bias; // length bias field
  logic [8:0] tx_total; // bytes on air for a transmit
  logic ser_busy; // serializer still shifting
  logic ser_bit; // serializer bit
  logic ser_valid; // serializer strobe
  logic [7:0] rx_byte; // byte completed this cycle
  logic [9:0] len_sum; // length byte plus bias
  logic [8:0] payload; // computed payload length
  logic [3:0] events; // event pulses this cycle

  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr_lane = req && wb_we_i && wb_sel_i[0];
  assign msb_first = s_q.format[pkt_pkg::BIT_ORDER_POS];
  assign fixed_size = s_q.format[pkt_pkg::FIXED_SIZE_POS];
  assign checksum_on = s_q.format[pkt_pkg::CHECKSUM_POS];
  // anything but the packet code is serial mode
  assign packet_mode =
    (s_q.format[pkt_pkg::MODE_LSB +: 2] == pkt_pkg::MODE_PACKET);
  assign bias = s_q.format[pkt_pkg::BIAS_LSB +: 3];
  // limit is the transmit length in both modes
  assign tx_total = {1'b0, s_q.limit} +
    (checksum_on ? pkt_pkg::CRC_BYTES : 9'h000);
  // byte assembly in the selected order
  assign rx_byte = msb_first ? {s_q.rx_sh[6:0], air_rx_bit} :
                               {air_rx_bit, s_q.rx_sh[7:1]};
  assign len_sum = {2'b00, rx_byte} + {7'h00, bias};
  // bias added, fixed correction removed, floored at zero
  assign payload = (len_sum < pkt_pkg::LENGTH_CORRECTION) ? 9'h000 :
    9'(len_sum - pkt_pkg::LENGTH_CORRECTION);
  assign tx_data_ready = (s_q.tx_st == T_FETCH) && !ser_busy &&
                         !s_q.ser_load && (s_q.tx_cnt < {1'b0, s_q.limit});

  // ----------------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------------
  byte_serializer u_ser (
    .clock(clock),
    .rst(rst),
    .load(s_q.ser_load),
    .data(s_q.ser_byte),
    .msb_first(msb_first),
    .busy(ser_busy),
    .bit_out(ser_bit),
    .bit_valid(ser_valid)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    events = 4'h0;
    s_d.ack = req;
    s_d.ser_load = 1'b0;
    s_d.wr_en = 1'b0;
    s_d.sp_valid = 1'b0;
    s_d.gp4 = 1'b0;

    // register writes
    if (wr_lane)
    begin
      if (reg_hit(wb_adr_i, pkt_pkg::IDX_FORMAT))
        s_d.format = wb_dat_i[7:0];
      if (reg_hit(wb_adr_i, pkt_pkg::IDX_LIMIT))
        s_d.limit = wb_dat_i[7:0];
      if (reg_hit(wb_adr_i, pkt_pkg::IDX_RX_START))
        s_d.rx_start = wb_dat_i[7:0];
      if (reg_hit(wb_adr_i, pkt_pkg::IDX_IRQ_MASK))
        s_d.irq_mask = wb_dat_i[3:0];
    end

    // register reads, unmapped reads zero
    s_d.rdata = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      if (reg_hit(wb_adr_i, pkt_pkg::IDX_FORMAT))
        s_d.rdata[7:0] = s_q.format;
      else if (reg_hit(wb_adr_i, pkt_pkg::IDX_LIMIT))
        s_d.rdata[7:0] = s_q.limit;
      else if (reg_hit(wb_adr_i, pkt_pkg::IDX_RX_START))
        s_d.rdata[7:0] = s_q.rx_start;
      else if (reg_hit(wb_adr_i, pkt_pkg::IDX_IRQ_MASK))
        s_d.rdata[3:0] = s_q.irq_mask;
      else if (reg_hit(wb_adr_i, pkt_pkg::IDX_RX_INFO))
        s_d.rdata[9:0] = {s_q.rx_crc_bad, s_q.rx_len};
      else if (reg_hit(wb_adr_i, pkt_pkg::IDX_IRQ_STATUS))
      begin
        s_d.rdata[3:0] = s_q.irq_status;
        // read clears; events below are ORed after this
        s_d.irq_status = 4'h0;
      end
    end

    // transmit sequencer, packet mode only
    case (s_q.tx_st)
      T_IDLE:
      begin
        if (tx_start && packet_mode)
        begin
          s_d.tx_st = T_FETCH;
          s_d.tx_cnt = 9'h000;
          s_d.tx_crc = pkt_pkg::CRC_INIT;
        end
      end
      T_FETCH:
      begin
        if (!ser_busy && !s_q.ser_load)
        begin
          if (s_q.tx_cnt < {1'b0, s_q.limit})
          begin
            if (tx_data_valid)
            begin
              s_d.ser_byte = tx_data;
              s_d.ser_load = 1'b1;
              s_d.tx_crc = pkt_pkg::crc_byte(s_q.tx_crc, tx_data);
              s_d.tx_cnt = s_q.tx_cnt + 9'h001;
            end
          end
          else if (s_q.tx_cnt < tx_total)
          begin
            // checksum, high byte first
            s_d.ser_byte = (s_q.tx_cnt == {1'b0, s_q.limit}) ?
                           s_q.tx_crc[15:8] : s_q.tx_crc[7:0];
            s_d.ser_load = 1'b1;
            s_d.tx_cnt = s_q.tx_cnt + 9'h001;
          end
          else
            s_d.tx_st = T_DRAIN;
        end
      end
      T_DRAIN:
      begin
        // last byte already left the serializer
        s_d.tx_st = T_IDLE;
        events[pkt_pkg::EV_TX_DONE] = 1'b1;
      end
      default:
        s_d.tx_st = T_IDLE;
    endcase

    // air output: serializer in packet mode, serial port otherwise
    s_d.air_bit = packet_mode ? ser_bit : sport_tx_bit;
    s_d.air_valid = packet_mode ? ser_valid : sport_tx_valid;

    // serial mode receive path and preamble signalling
    if (!packet_mode)
    begin
      s_d.sp_bit = air_rx_bit;
      s_d.sp_valid = air_rx_valid;
      if (preamble_detect)
      begin
        s_d.gp4 = 1'b1;
        events[pkt_pkg::EV_PREAMBLE] = 1'b1;
      end
    end

    // receive sequencer
    case (s_q.rx_st)
      R_IDLE:
      begin
        if (rx_sync && packet_mode)
        begin
          s_d.rx_st = R_RECV;
          s_d.rx_bits = 3'h0;
          s_d.rx_cnt = 9'h000;
          s_d.rx_crc = pkt_pkg::CRC_INIT;
          // fixed mode knows the count now
          s_d.rx_target = {1'b0, s_q.limit};
          s_d.rx_keep = {1'b0, s_q.limit};
        end
      end
      R_RECV:
      begin
        if (!packet_mode)
          s_d.rx_st = R_IDLE;
        else if (air_rx_valid)
        begin
          s_d.rx_sh = rx_byte;
          s_d.rx_bits = s_q.rx_bits + 3'h1;
          if (s_q.rx_bits == 3'h7)
          begin
            s_d.rx_cnt = s_q.rx_cnt + 9'h001;
            if (s_q.rx_cnt == 9'h000 && !fixed_size)
            begin
              // first byte is the length byte
              s_d.rx_target = payload;
              s_d.rx_len = payload;
              s_d.rx_keep = (payload > {1'b0, s_q.limit}) ?
                            {1'b0, s_q.limit} : payload;
            end
            else if (s_q.rx_cnt == 9'h000)
              s_d.rx_len = {1'b0, s_q.limit};
            if (s_q.rx_cnt < s_d.rx_target)
            begin
              s_d.rx_crc = pkt_pkg::crc_byte(s_q.rx_crc, rx_byte);
              if (s_q.rx_cnt < s_d.rx_keep)
              begin
                s_d.wr_en = 1'b1;
                s_d.wr_addr = 8'(s_q.rx_start + s_q.rx_cnt[7:0]);
                s_d.wr_data = rx_byte;
              end
            end
            else if (s_q.rx_cnt == s_d.rx_target)
              s_d.rx_crc_hi = rx_byte;
            // end of packet: data done, then checksum if enabled
            if (s_d.rx_cnt == s_d.rx_target && !checksum_on)
            begin
              s_d.rx_st = R_IDLE;
              s_d.rx_crc_bad = 1'b0;
              events[pkt_pkg::EV_RX_DONE] = 1'b1;
            end
            else if (s_d.rx_cnt == s_d.rx_target + pkt_pkg::CRC_BYTES)
            begin
              s_d.rx_st = R_IDLE;
              s_d.rx_crc_bad =
                ({s_q.rx_crc_hi, rx_byte} != s_q.rx_crc);
              events[pkt_pkg::EV_RX_DONE] = 1'b1;
              events[pkt_pkg::EV_CRC_BAD] = s_d.rx_crc_bad;
            end
          end
        end
      end
      default:
        s_d.rx_st = R_IDLE;
    endcase

    // set wins over the read clear
    s_d.irq_status = s_d.irq_status | events;
  end

  // ----------------------------------------------------------------------
  // register the state
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.format <= pkt_pkg::FORMAT_RESET;
      s_q.limit <= pkt_pkg::LIMIT_RESET;
      s_q.rx_start <= pkt_pkg::RX_START_RESET;
      s_q.irq_mask <= pkt_pkg::MASK_RESET;
      s_q.tx_st <= T_IDLE;
      s_q.rx_st <= R_IDLE;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign irq = |(s_q.irq_status & s_q.irq_mask);
  assign air_tx_bit = s_q.air_bit;
  assign air_tx_valid = s_q.air_valid;
  assign buf_wr_en = s_q.wr_en;
  assign buf_wr_addr = s_q.wr_addr;
  assign buf_wr_data = s_q.wr_data;
  assign sport_rx_bit = s_q.sp_bit;
  assign sport_rx_valid = s_q.sp_valid;
  assign general_pin_four = s_q.gp4;
endmodule : packet_length_format_control
`default_nettype wire

// File: sim/pkt_properties.sv
// Purpose: port-level properties of the packet format block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module pkt_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_data_valid,
  input wire logic tx_data_ready,
  input wire logic air_tx_valid,
  input wire logic air_rx_bit,
  input wire logic air_rx_valid,
  input wire logic buf_wr_en,
  input wire logic preamble_detect,
  input wire logic sport_rx_bit,
  input wire logic sport_rx_valid,
  input wire logic general_pin_four
);
  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:10] == 22'h00_0000)
    else $error("read data upper bits not zero");
  // ------------------------------------------------------------------
  // air and buffer side
  // ------------------------------------------------------------------
  a_tx_byte_run: assert property (
    $rose(air_tx_valid) |-> air_tx_valid [*8] ##1 !air_tx_valid)
    else $error("transmit byte is not eight consecutive bits");
  a_fetch_gap: assert property (
    tx_data_valid && tx_data_ready |=> !tx_data_ready [*8])
    else $error("next byte fetched before current byte is sent");
  a_buf_after_bit: assert property (
    buf_wr_en |-> $past(air_rx_valid))
    else $error("buffer write without a bit just before");
  a_pin_cause: assert property (
    general_pin_four |-> $past(preamble_detect))
    else $error("pin four pulse without a preamble");
  a_sport_copy: assert property (
    sport_rx_valid |-> $past(air_rx_valid) &&
    sport_rx_bit == $past(air_rx_bit))
    else $error("serial receive bit is not the air bit");
endmodule : pkt_checker
bind packet_length_format_control pkt_checker u_pkt_checker (.clock, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_data_valid,
  .tx_data_ready, .air_tx_valid, .air_rx_bit, .air_rx_valid, .buf_wr_en,
  .preamble_detect, .sport_rx_bit, .sport_rx_valid, .general_pin_four);
`default_nettype wire

// File: sim/remote_transceiver.sv
// Purpose: behavioural far-end radio on the air bit lines
// Assumes: bit order given by msb_first, same as the local setting
// Notes: idle data line shows the inverse of the last bit sent
`timescale 1ns/1ps
`default_nettype none
module remote_transceiver (
  input wire logic clock,
  input wire logic msb_first,
  input wire logic air_tx_bit,
  input wire logic air_tx_valid,
  output logic air_rx_bit,
  output logic air_rx_valid
);
  logic [7:0] got[$]; // bytes heard from the device
  logic [7:0] sh; // bit gatherer
  logic [2:0] cnt; // bits gathered so far
  initial
  begin
    air_rx_bit = 1'b0;
    air_rx_valid = 1'b0;
    sh = 8'h00;
    cnt = 3'h0;
  end
  // gather air bits into bytes in the agreed order
  always @(posedge clock)
  begin
    if (air_tx_valid === 1'b1)
    begin
      sh = msb_first ? {sh[6:0], air_tx_bit} : {air_tx_bit, sh[7:1]};
      if (cnt == 3'h7)
        got.push_back(sh);
      cnt = cnt + 3'h1;
    end
  end
  // send one byte, one bit a cycle, then leave the line unreliable
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      air_rx_valid <= 1'b1;
      air_rx_bit <= msb_first ? b[7 - i] : b[i];
    end
    @(posedge clock);
    air_rx_valid <= 1'b0;
    air_rx_bit <= ~(msb_first ? b[0] : b[7]);
  endtask : send_byte
endmodule : remote_transceiver
`default_nettype wire

// File: sim/testbench.sv
// Purpose: register, transmit, receive and serial tests of the block
// Assumes: one-cycle Wishbone answer, register writes in the low byte
// Notes: serial transmit sends ones
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, sport_tx_valid;
  logic tx_start, tx_data_valid, tx_data_ready, rx_sync, preamble_detect;
  logic air_tx_bit, air_tx_valid, air_rx_bit, air_rx_valid, ord, sport_tx_bit;
  logic buf_wr_en, sport_rx_bit, sport_rx_valid, general_pin_four;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_dat;
  logic [7:0] buf_wr_addr, buf_wr_data, tx_n, tx_data;
  logic [15:0] wr_q[$]; // buffer writes seen, address and data
  int n_fail, cmp_count;
  assign tx_data = {tx_n[3:0], ~tx_n[3:0]}; // low nibble is the inverse of the high nibble
  packet_length_format_control u_packet_length_format_control (.clock,
    .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .tx_start, .tx_data,
    .tx_data_valid, .tx_data_ready, .air_tx_bit, .air_tx_valid,
    .air_rx_bit, .air_rx_valid, .rx_sync, .preamble_detect, .buf_wr_en,
    .buf_wr_addr, .buf_wr_data, .sport_tx_bit, .sport_tx_valid,
    .sport_rx_bit, .sport_rx_valid, .general_pin_four);
  remote_transceiver u_remote_transceiver (.clock, .msb_first(ord),
    .air_tx_bit, .air_tx_valid, .air_rx_bit, .air_rx_valid);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // record buffer writes and advance the byte source
  always @(posedge clock)
  begin
    if (buf_wr_en === 1'b1)
      wr_q.push_back({buf_wr_addr, buf_wr_data});
    if (tx_data_valid && tx_data_ready === 1'b1)
      tx_n <= tx_n + 8'h01;
  end
  // ------------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------------
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    rd_dat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
      n_fail++;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [9:0] i, input logic [31:0] exp);
    wb(1'b0, i, 8'h00);
    chk(rd_dat, exp);
  endtask : rd
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // ------------------------------------------------------------------
  // transmit and receive cases
  // ------------------------------------------------------------------
  // one transmit frame, then compare the bytes the far end heard
  task automatic tx_case(input logic [7:0] fmt, input logic [7:0] lim,
                         input int nb);
    logic [7:0] base;
    ord = fmt[7];
    wb(1'b1, pkt_pkg::IDX_FORMAT, fmt);
    wb(1'b1, pkt_pkg::IDX_LIMIT, lim);
    u_remote_transceiver.got.delete();
    base = tx_n;
    tx_start <= 1'b1;
    tx_data_valid <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    repeat (nb * 12 + 30) @(posedge clock);
    tx_data_valid <= 1'b0;
    chk(32'(u_remote_transceiver.got.size()), 32'(nb));
    for (int k = 0; k < lim; k++)
      chk(32'(u_remote_transceiver.got[k]),
          32'({4'(base + k), ~4'(base + k)}));
  endtask : tx_case
  // one receive frame, then compare buffer writes and status
  task automatic rx_case(input logic [7:0] fmt, input logic [7:0] lim,
    input logic [7:0] start, input logic [7:0] first, input int nb,
    input int nw, input logic [31:0] st);
    ord = fmt[7];
    wb(1'b1, pkt_pkg::IDX_FORMAT, fmt);
    wb(1'b1, pkt_pkg::IDX_LIMIT, lim);
    wb(1'b1, pkt_pkg::IDX_RX_START, start);
    wr_q.delete();
    rx_sync <= 1'b1;
    @(posedge clock);
    rx_sync <= 1'b0;
    for (int k = 0; k < nb; k++)
      u_remote_transceiver.send_byte(k == 0 ? first : 8'(8'h50 + k));
    repeat (5) @(posedge clock);
    chk(32'(wr_q.size()), 32'(nw));
    for (int k = 0; k < nw; k++)
      chk(32'(wr_q[k]), 32'({8'(start + k),
          k == 0 ? first : 8'(8'h50 + k)}));
    rd(pkt_pkg::IDX_IRQ_STATUS, st);
  endtask : rx_case
  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    final_report();
  end
  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, tx_start, tx_data_valid} = 6'h20;
    {rx_sync, preamble_detect, ord, sport_tx_bit, sport_tx_valid} = 5'h00;
    wb_adr_i = 12'h000;
    wb_dat_i = 32'h0000_0000;
    tx_n = 8'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(pkt_pkg::IDX_FORMAT, 32'h0000_0000);
    rd(pkt_pkg::IDX_LIMIT, 32'h0000_0000);
    rd(pkt_pkg::IDX_RX_START, 32'h0000_0000);
    rd(pkt_pkg::IDX_IRQ_MASK, 32'h0000_0000);
    rd(10'h03f, 32'h0000_0000); // unmapped word reads zero
    wb(1'b1, pkt_pkg::IDX_LIMIT, 8'h9c);
    rd(pkt_pkg::IDX_LIMIT, 32'h0000_009c);
    tx_case(8'hc0, 8'h03, 3);
    rd(pkt_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    wb(1'b1, pkt_pkg::IDX_IRQ_MASK, 8'h01);
    chk(32'(irq), 32'h0000_0000);
    tx_case(8'h20, 8'h02, 4);
    chk(32'(irq), 32'h0000_0001);
    rd(pkt_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    rd(pkt_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    rx_case(8'h85, 8'h04, 8'h10, 8'h09, 10, 4, 32'h0000_0002);
    rd(pkt_pkg::IDX_RX_INFO, 32'h0000_000a);
    rx_case(8'h03, 8'h10, 8'hfe, 8'h04, 5, 3, 32'h0000_0002);
    rx_case(8'hc0, 8'h02, 8'h40, 8'h09, 4, 2, 32'h0000_0002);
    rx_case(8'he0, 8'h02, 8'h40, 8'h09, 4, 2, 32'h0000_0006);
    // serial mode: preamble pin, refused transmit, streamed bits
    wb(1'b1, pkt_pkg::IDX_FORMAT, 8'h08);
    wb(1'b1, pkt_pkg::IDX_IRQ_MASK, 8'h08);
    preamble_detect <= 1'b1;
    @(posedge clock);
    preamble_detect <= 1'b0;
    @(posedge clock);
    chk(32'(general_pin_four), 32'h0000_0001);
    u_remote_transceiver.got.delete();
    u_remote_transceiver.send_byte(8'ha5);
    {sport_tx_bit, sport_tx_valid} <= 2'h3;
    repeat (8) @(posedge clock);
    sport_tx_valid <= 1'b0;
    tx_start <= 1'b1;
    tx_data_valid <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    repeat (30) @(posedge clock);
    chk(32'(u_remote_transceiver.got.size()), 32'h0000_0001);
    chk(32'(u_remote_transceiver.got[0]), 32'h0000_00ff);
    chk(32'(irq), 32'h0000_0001);
    rd(pkt_pkg::IDX_IRQ_STATUS, 32'h0000_0008);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0000_0000);
    final_report();
  end
endmodule : testbench
`default_nettype wire
